// [hdl/fiob_bank.sv]
// Purpose: local register bank with tx/rx fifos, pll, led, ttl and ecl i/o
// Assumes: local bus strobes are one-cycle pulses synchronous to clk_i
// Notes: read data appears one cycle after the read strobe
`default_nettype none
module fiob_bank #(
  parameter int BLINK_HALF_CYC = fiob_pkg::BLINK_HALF_CYC,
  parameter int INT_DEPTH = fiob_pkg::INT_DEPTH,
  parameter int EXT_DEPTH = fiob_pkg::EXT_DEPTH
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // local bus
  input wire logic [fiob_pkg::ADDR_W-1:0] lb_addr_i,
  input wire logic lb_wr_i,
  input wire logic lb_rd_i,
  input wire logic [31:0] lb_wdata_i,
  output logic [31:0] lb_rdata_o,
  output logic lb_rack_o,
  output logic lb_data_oe_n_o,
  // transmit engine
  output logic tx_start_o,
  output logic [31:0] tx_word_o,
  output logic tx_word_valid_o,
  input wire logic tx_take_i,
  // receive engine
  output logic rx_start_o,
  input wire logic rx_wr_i,
  input wire logic [31:0] rx_wdata_i,
  // host interrupt
  output logic irq_o,
  // user led
  output logic led_o,
  // pll serial programming
  output logic pll_sclk_o,
  output logic pll_s2_o,
  output logic pll_sdata_o,
  output logic pll_sdata_oe_n_o,
  input wire logic pll_sdata_i,
  // ttl lines, open drain
  input wire logic [fiob_pkg::TTL_W-1:0] ttl_i,
  output logic [fiob_pkg::TTL_W-1:0] ttl_o,
  output logic [fiob_pkg::TTL_W-1:0] ttl_oe_n_o,
  // spare ecl lines
  input wire logic [fiob_pkg::ECL_W-1:0] ecl_i,
  output logic [fiob_pkg::ECL_W-1:0] ecl_o
);
  localparam int ECW = $clog2(EXT_DEPTH + 1);
  localparam int ICW = $clog2(INT_DEPTH + 1);

  logic [31:0] ctrl_ff;
  logic [3:0] latch_ff;
  logic [fiob_pkg::LVL_W-1:0] ae_lvl_ff;
  logic [fiob_pkg::LVL_W-1:0] af_lvl_ff;
  logic tx_ae_prev_ff;
  logic rx_af_prev_ff;
  logic [31:0] tx_pf_ff;
  logic tx_dv_ff;
  logic [31:0] rx_pf_ff;
  logic rx_dv_ff;
  logic blink;

  // bus decode
  logic wr_ctrl;
  logic wr_stat;
  logic wr_fifo;
  logic rd_fifo;
  assign wr_ctrl = lb_wr_i & (lb_addr_i == fiob_pkg::OFS_CTRL);
  assign wr_stat = lb_wr_i & (lb_addr_i == fiob_pkg::OFS_STAT);
  assign wr_fifo = lb_wr_i & (lb_addr_i == fiob_pkg::OFS_FIFO);
  assign rd_fifo = lb_rd_i & (lb_addr_i == fiob_pkg::OFS_FIFO);

  // control fields
  logic ext_sel;
  logic loop_en;
  logic tx_run;
  logic tx_rst;
  logic rx_rst;
  assign ext_sel = ctrl_ff[fiob_pkg::C_EXT];
  assign loop_en = ctrl_ff[fiob_pkg::C_LOOP];
  assign tx_run = ctrl_ff[fiob_pkg::C_TX_START];
  assign tx_rst = ctrl_ff[fiob_pkg::C_TX_RST];
  assign rx_rst = ctrl_ff[fiob_pkg::C_RX_RST];

  // logical tx/rx fifo sides
  logic tx_in_ready;
  logic tx_out_valid;
  logic [31:0] tx_out_data;
  logic tx_pop;
  logic [31:0] tx_cnt;
  logic rx_push;
  logic [31:0] rx_push_data;
  logic rx_in_ready;
  logic rx_out_valid;
  logic [31:0] rx_out_data;
  logic rx_pop;
  logic [31:0] rx_cnt;

  // physical fifos
  logic e_in_ready;
  logic e_out_valid;
  logic [31:0] e_out_data;
  logic [ECW-1:0] e_cnt;
  logic i_in_ready;
  logic i_out_valid;
  logic [31:0] i_out_data;
  logic [ICW-1:0] i_cnt;

  fiob_fifo #(
    .WIDTH(32),
    .DEPTH(EXT_DEPTH)
  ) u_ext_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clr_i(ext_sel ? tx_rst : rx_rst),
    .in_valid_i(ext_sel ? wr_fifo : rx_push),
    .in_data_i(ext_sel ? lb_wdata_i : rx_push_data),
    .in_ready_o(e_in_ready),
    .out_valid_o(e_out_valid),
    .out_data_o(e_out_data),
    .out_ready_i(ext_sel ? tx_pop : rx_pop),
    .count_o(e_cnt)
  );

  fiob_fifo #(
    .WIDTH(32),
    .DEPTH(INT_DEPTH)
  ) u_int_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clr_i(ext_sel ? rx_rst : tx_rst),
    .in_valid_i(ext_sel ? rx_push : wr_fifo),
    .in_data_i(ext_sel ? rx_push_data : lb_wdata_i),
    .in_ready_o(i_in_ready),
    .out_valid_o(i_out_valid),
    .out_data_o(i_out_data),
    .out_ready_i(ext_sel ? rx_pop : tx_pop),
    .count_o(i_cnt)
  );

  // role swap on the external-fifo select
  assign tx_in_ready = ext_sel ? e_in_ready : i_in_ready;
  assign tx_out_valid = ext_sel ? e_out_valid : i_out_valid;
  assign tx_out_data = ext_sel ? e_out_data : i_out_data;
  assign tx_cnt = ext_sel ? 32'(e_cnt) : 32'(i_cnt);
  assign rx_in_ready = ext_sel ? i_in_ready : e_in_ready;
  assign rx_out_valid = ext_sel ? i_out_valid : e_out_valid;
  assign rx_out_data = ext_sel ? i_out_data : e_out_data;
  assign rx_cnt = ext_sel ? 32'(i_cnt) : 32'(e_cnt);

  // tx drain: engine takes, or loop-back moves into rx when rx has room
  logic tx_consume;
  logic tx_done_evt;
  assign tx_consume = tx_dv_ff &
    (loop_en ? rx_in_ready : (tx_take_i & tx_run));
  // refill the holding word only while it is empty or being emptied
  assign tx_pop = (tx_run | loop_en) & (~tx_dv_ff | tx_consume);
  assign tx_done_evt = tx_run & ~loop_en & tx_take_i & ~tx_dv_ff;

  // rx fill: engine, or loop-back from the tx holding word
  logic rx_ovr_evt;
  assign rx_push = loop_en ? tx_consume : rx_wr_i;
  assign rx_push_data = loop_en ? tx_pf_ff : rx_wdata_i;
  assign rx_ovr_evt = ~loop_en & rx_wr_i & ~rx_in_ready;
  assign rx_pop = ~rx_dv_ff | (rd_fifo & rx_dv_ff);

  // live fifo flags
  logic tx_ae;
  logic rx_af;
  assign tx_ae = tx_cnt <= 32'(ae_lvl_ff);
  assign rx_af = rx_cnt >= 32'(af_lvl_ff);

  // interrupt causes
  logic int_act;
  assign int_act = |(latch_ff & ctrl_ff[fiob_pkg::C_IE_LO +: 4]) |
    ctrl_ff[fiob_pkg::C_FORCE];

  // control register; start/stop enable is never stored
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_ff <= fiob_pkg::CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_ff <= (lb_wdata_i & fiob_pkg::CTRL_MASK) |
        (ctrl_ff & 32'h00002000);
      if (lb_wdata_i[fiob_pkg::C_SS_EN]) begin
        ctrl_ff[fiob_pkg::C_TX_START] <=
          lb_wdata_i[fiob_pkg::C_TX_START];
      end
    end else if (tx_done_evt & ctrl_ff[fiob_pkg::C_AUTOCLR]) begin
      ctrl_ff[fiob_pkg::C_TX_START] <= 1'b0;
    end
  end

  // level registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ae_lvl_ff <= '0;
      af_lvl_ff <= '0;
    end else if (lb_wr_i) begin
      if (lb_addr_i == fiob_pkg::OFS_AE_LVL) begin
        ae_lvl_ff <= lb_wdata_i[fiob_pkg::LVL_W-1:0];
      end
      if (lb_addr_i == fiob_pkg::OFS_AF_LVL) begin
        af_lvl_ff <= lb_wdata_i[fiob_pkg::LVL_W-1:0];
      end
    end
  end

  // i/o latches; a one releases the ttl line
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ttl_oe_n_o <= '1;
      ecl_o <= '0;
    end else if (lb_wr_i) begin
      if (lb_addr_i == fiob_pkg::OFS_TTL_OUT) begin
        ttl_oe_n_o <= lb_wdata_i[fiob_pkg::TTL_W-1:0];
      end
      if (lb_addr_i == fiob_pkg::OFS_ECL_OUT) begin
        ecl_o <= lb_wdata_i[fiob_pkg::ECL_W-1:0];
      end
    end
  end
  assign ttl_o = '0;

  // tx holding word
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_pf_ff <= 32'h0;
      tx_dv_ff <= 1'b0;
    end else if (tx_rst) begin
      tx_dv_ff <= 1'b0;
    end else if (tx_pop & tx_out_valid) begin
      tx_pf_ff <= tx_out_data;
      tx_dv_ff <= 1'b1;
    end else if (tx_consume) begin
      tx_dv_ff <= 1'b0;
    end
  end
  assign tx_word_o = tx_pf_ff;
  assign tx_word_valid_o = tx_dv_ff;
  assign tx_start_o = tx_run;
  assign rx_start_o = ctrl_ff[fiob_pkg::C_RX_START];

  // rx holding word, filled as soon as the fifo has data
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_pf_ff <= 32'h0;
      rx_dv_ff <= 1'b0;
    end else if (rx_rst) begin
      rx_dv_ff <= 1'b0;
    end else if (rx_pop & rx_out_valid) begin
      rx_pf_ff <= rx_out_data;
      rx_dv_ff <= 1'b1;
    end else if (rd_fifo & rx_dv_ff) begin
      rx_dv_ff <= 1'b0;
    end
  end

  // sticky events; a set in the clear cycle wins
  logic [3:0] set_vec;
  logic [3:0] clr_vec;
  assign set_vec = {rx_af & ~rx_af_prev_ff,
                    tx_ae & ~tx_ae_prev_ff,
                    rx_ovr_evt,
                    tx_done_evt};
  assign clr_vec = wr_stat ?
    lb_wdata_i[fiob_pkg::S_LATCH_LO +: 4] : 4'h0;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      latch_ff <= 4'h0;
      tx_ae_prev_ff <= 1'b0;
      rx_af_prev_ff <= 1'b0;
    end else begin
      latch_ff <= (latch_ff & ~clr_vec) | set_vec;
      tx_ae_prev_ff <= tx_ae;
      rx_af_prev_ff <= rx_af;
    end
  end

  // status word
  logic [31:0] stat;
  always_comb begin
    stat = 32'h0;
    stat[fiob_pkg::S_TX_EMPTY] = ~tx_out_valid;
    stat[fiob_pkg::S_TX_AE] = tx_ae;
    stat[fiob_pkg::S_TX_FULL] = ~tx_in_ready;
    stat[fiob_pkg::S_TX_DV] = tx_dv_ff;
    stat[fiob_pkg::S_RX_EMPTY] = ~rx_out_valid;
    stat[fiob_pkg::S_RX_AF] = rx_af;
    stat[fiob_pkg::S_RX_FULL] = ~rx_in_ready;
    stat[fiob_pkg::S_RX_DV] = rx_dv_ff;
    stat[fiob_pkg::S_LATCH_LO +: 4] = latch_ff;
    stat[fiob_pkg::S_INT_ACT] = int_act;
    // readback only while the pll lines are enabled
    stat[fiob_pkg::S_SDATA_IN] =
      ctrl_ff[fiob_pkg::C_PLL_EN] & pll_sdata_i;
  end

  // read mux; unmapped offsets read zero
  logic [31:0] rd_mux;
  always_comb begin
    unique case (lb_addr_i)
      fiob_pkg::OFS_CTRL: rd_mux = ctrl_ff;
      fiob_pkg::OFS_STAT: rd_mux = stat;
      fiob_pkg::OFS_FIFO: rd_mux = rx_dv_ff ? rx_pf_ff : 32'h0;
      fiob_pkg::OFS_TTL_OUT: rd_mux = 32'(ttl_oe_n_o);
      fiob_pkg::OFS_TTL_IN: rd_mux = 32'(ttl_i);
      fiob_pkg::OFS_ECL_OUT: rd_mux = 32'(ecl_o);
      fiob_pkg::OFS_ECL_IN: rd_mux = 32'(ecl_i);
      fiob_pkg::OFS_TX_CNT: rd_mux = tx_cnt;
      fiob_pkg::OFS_AE_LVL: rd_mux = 32'(ae_lvl_ff);
      fiob_pkg::OFS_AF_LVL: rd_mux = 32'(af_lvl_ff);
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      lb_rdata_o <= 32'h0;
      lb_rack_o <= 1'b0;
      lb_data_oe_n_o <= 1'b1;
    end else begin
      lb_rdata_o <= lb_rd_i ? rd_mux : 32'h0;
      lb_rack_o <= lb_rd_i;
      lb_data_oe_n_o <= ~lb_rd_i;
    end
  end

  // interrupt to host needs the master enable
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= int_act & ctrl_ff[fiob_pkg::C_MIE];
    end
  end

  fiob_blink #(
    .HALF_CYC(BLINK_HALF_CYC)
  ) u_blink (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .blink_o(blink)
  );

  // led and pll pins, registered one cycle after the control word
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      led_o <= 1'b0;
      pll_sclk_o <= 1'b0;
      pll_s2_o <= 1'b0;
      pll_sdata_oe_n_o <= 1'b1;
    end else begin
      led_o <= ctrl_ff[fiob_pkg::C_LED_EN] ?
        ctrl_ff[fiob_pkg::C_LED_ON] : blink;
      pll_sclk_o <= ctrl_ff[fiob_pkg::C_PLL_EN] &
        ctrl_ff[fiob_pkg::C_SCLK];
      pll_s2_o <= ctrl_ff[fiob_pkg::C_S2];
      // open drain: pull low only for a zero data bit
      pll_sdata_oe_n_o <= ~(ctrl_ff[fiob_pkg::C_PLL_EN] &
        ~ctrl_ff[fiob_pkg::C_SDATA]);
    end
  end
  assign pll_sdata_o = 1'b0;
endmodule
`default_nettype wire

// [hdl/fiob_pkg.sv]
// Purpose: shared constants for the fifo and i/o register bank
// Assumes: 125 MHz clock, byte addresses on a 6-bit local bus
`default_nettype none
package fiob_pkg;
  localparam int ADDR_W = 6;
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_STAT = 6'h04;
  localparam logic [5:0] OFS_FIFO = 6'h0C;
  localparam logic [5:0] OFS_TTL_OUT = 6'h14;
  localparam logic [5:0] OFS_TTL_IN = 6'h18;
  localparam logic [5:0] OFS_ECL_OUT = 6'h1C;
  localparam logic [5:0] OFS_ECL_IN = 6'h20;
  localparam logic [5:0] OFS_TX_CNT = 6'h24;
  localparam logic [5:0] OFS_AE_LVL = 6'h2C;
  localparam logic [5:0] OFS_AF_LVL = 6'h38;
  // control bit positions
  localparam int C_TX_RST = 0;
  localparam int C_RX_RST = 1;
  localparam int C_LOOP = 3;
  localparam int C_MIE = 4;
  localparam int C_FORCE = 5;
  localparam int C_EXT = 6;
  localparam int C_AUTOCLR = 7;
  localparam int C_IE_LO = 8;
  localparam int C_RX_START = 12;
  localparam int C_TX_START = 13;
  localparam int C_SS_EN = 14;
  localparam int C_LED_EN = 15;
  localparam int C_LED_ON = 16;
  localparam int C_SCLK = 20;
  localparam int C_S2 = 21;
  localparam int C_SDATA = 22;
  localparam int C_PLL_EN = 23;
  // stored control bits; start/stop enable is absent on purpose
  localparam logic [31:0] CTRL_MASK = 32'h00F19FFF;
  localparam logic [31:0] CTRL_RST = 32'h00000000;
  // status bit positions
  localparam int S_TX_EMPTY = 0;
  localparam int S_TX_AE = 1;
  localparam int S_TX_FULL = 2;
  localparam int S_TX_DV = 3;
  localparam int S_RX_EMPTY = 4;
  localparam int S_RX_AF = 5;
  localparam int S_RX_FULL = 6;
  localparam int S_RX_DV = 7;
  localparam int S_LATCH_LO = 8;
  localparam int S_INT_ACT = 13;
  localparam int S_SDATA_IN = 15;
  localparam int LVL_W = 12;
  localparam int TTL_W = 12;
  localparam int ECL_W = 8;
  localparam int INT_DEPTH = 8;
  localparam int EXT_DEPTH = 16;
  // led blink: half period in ms, cycles derived from the clock rate
  localparam int CLK_KHZ = 125000;
  localparam int BLINK_HALF_MS = 250;
  localparam int BLINK_HALF_CYC = CLK_KHZ * BLINK_HALF_MS;
endpackage
`default_nettype wire

// [hdl/fiob_fifo.sv]
// Purpose: synchronous word fifo with valid/ready on both sides
// Assumes: one clock; clr_i empties it in one cycle
// Notes: count is exact, full and empty come straight from it
`default_nettype none
module fiob_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8,
  parameter int CW = $clog2(DEPTH + 1)
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clr_i,
  // fill side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // drain side
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i,
  // level
  output logic [CW-1:0] count_o
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wp_ff;
  logic [PW-1:0] rp_ff;
  logic [CW-1:0] cnt_ff;
  logic push;
  logic pop;

  assign in_ready_o = (cnt_ff != CW'(DEPTH));
  assign out_valid_o = (cnt_ff != '0);
  assign out_data_o = mem[rp_ff];
  assign count_o = cnt_ff;
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  function automatic logic [PW-1:0] inc(input logic [PW-1:0] p);
    inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wp_ff] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
    end else if (clr_i) begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wp_ff <= inc(wp_ff);
      end
      if (pop) begin
        rp_ff <= inc(rp_ff);
      end
      cnt_ff <= cnt_ff + CW'(push) - CW'(pop);
    end
  end
endmodule
`default_nettype wire

// [hdl/fiob_blink.sv]
// Purpose: free-running square wave for the user led
// Assumes: HALF_CYC >= 1
// Notes: period is two half periods, so two flashes a second by default
`default_nettype none
module fiob_blink #(
  parameter int HALF_CYC = fiob_pkg::BLINK_HALF_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wave
  output logic blink_o
);
  logic [31:0] cnt_ff;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_ff <= 32'h0;
      blink_o <= 1'b0;
    end else if (cnt_ff == 32'(HALF_CYC - 1)) begin
      cnt_ff <= 32'h0;
      blink_o <= ~blink_o;
    end else begin
      cnt_ff <= cnt_ff + 32'h1;
    end
  end
endmodule
`default_nettype wire

// [tb/fiob_lines.sv]
// Purpose: board wiring of the ttl lines and the pll data line
// Assumes: a pull-up on every ttl line and on the pll data line
// Notes: an outside driver can only pull a line low
`default_nettype none
module fiob_lines (
  // ttl lines
  input wire logic [11:0] ttl_o_i,
  input wire logic [11:0] ttl_oe_n_i,
  input wire logic [11:0] ext_low_i,
  output logic [11:0] ttl_lvl_o,
  // pll data line
  input wire logic sd_o_i,
  input wire logic sd_oe_n_i,
  input wire logic pll_low_i,
  output logic sd_lvl_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // a released line floats up, it never keeps the last driven level
  assign ttl_lvl_o = ~(~ttl_oe_n_i & ~ttl_o_i) & ~ext_low_i;
  assign sd_lvl_o = (sd_oe_n_i | sd_o_i) & ~pll_low_i;
endmodule
`default_nettype wire

// [tb/fiob_bank_asserts.sv]
// Purpose: port-level checks for the register bank
// Assumes: one clock; shadows track what the host wrote
// Notes: pin checks wait until three cycles after any write
`default_nettype none
module fiob_bank_asserts (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // local bus
  input wire logic [5:0] lb_addr_i,
  input wire logic lb_wr_i,
  input wire logic lb_rd_i,
  input wire logic [31:0] lb_wdata_i,
  input wire logic [31:0] lb_rdata_o,
  input wire logic lb_rack_o,
  input wire logic lb_data_oe_n_o,
  // engine, irq, pins
  input wire logic tx_start_o,
  input wire logic tx_take_i,
  input wire logic irq_o,
  input wire logic led_o,
  input wire logic pll_sclk_o,
  input wire logic pll_sdata_o,
  input wire logic pll_sdata_oe_n_o,
  input wire logic [11:0] ttl_i,
  input wire logic [11:0] ttl_o,
  input wire logic [11:0] ttl_oe_n_o,
  input wire logic [7:0] ecl_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] ctl_ff;
  logic [11:0] ttl_ff;
  logic [7:0] ecl_ff;
  logic [1:0] age_ff;
  logic ss_wr;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  assign ss_wr = lb_wr_i && lb_addr_i == 6'h00 && lb_wdata_i[14];
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctl_ff <= 32'h0;
      ttl_ff <= 12'hFFF;
      ecl_ff <= 8'h0;
    end else if (lb_wr_i) begin
      if (lb_addr_i == 6'h00) ctl_ff <= lb_wdata_i;
      if (lb_addr_i == 6'h14) ttl_ff <= lb_wdata_i[11:0];
      if (lb_addr_i == 6'h1C) ecl_ff <= lb_wdata_i[7:0];
    end
  end
  // saturating, so pins are judged only once their registers settled
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) age_ff <= 2'h3;
    else if (lb_wr_i) age_ff <= 2'h0;
    else if (age_ff != 2'h3) age_ff <= age_ff + 2'h1;
  end
  a_led_on: assert property (
    age_ff == 2'h3 && ctl_ff[15] |-> led_o == ctl_ff[16])
    else $error("led not set by led-on bit");
  a_sclk_gate: assert property (
    age_ff == 2'h3 |-> pll_sclk_o == (ctl_ff[20] && ctl_ff[23]))
    else $error("pll clock wrong");
  a_sdata_drive: assert property (
    age_ff == 2'h3 |-> !pll_sdata_o &&
    pll_sdata_oe_n_o == !(ctl_ff[23] && !ctl_ff[22]))
    else $error("pll data drive wrong");
  a_ttl_release: assert property (
    age_ff == 2'h3 |-> ttl_oe_n_o == ttl_ff && ttl_o == 12'h0)
    else $error("ttl drive differs from latch");
  a_ecl_latch: assert property (
    age_ff == 2'h3 |-> ecl_o == ecl_ff)
    else $error("ecl lines differ from latch");
  a_ttl_levels: assert property (
    lb_rd_i && lb_addr_i == 6'h18 && $stable(ttl_i)
    |=> lb_rdata_o == {20'h0, $past(ttl_i)})
    else $error("ttl input port wrong");
  a_read_idle: assert property (
    !lb_rd_i |=> lb_rdata_o == 32'h0 && !lb_rack_o && lb_data_oe_n_o)
    else $error("read data outside a read");
  a_read_answer: assert property (
    lb_rd_i |=> lb_rack_o && !lb_data_oe_n_o)
    else $error("read not answered next cycle");
  a_irq_gate: assert property (
    age_ff == 2'h3 && !ctl_ff[4] |-> !irq_o)
    else $error("irq without master enable");
  a_irq_force: assert property (
    age_ff == 2'h3 && ctl_ff[4] && ctl_ff[5] |-> irq_o)
    else $error("forced irq missing");
  a_start_cause: assert property (
    $changed(tx_start_o) |-> $past(ss_wr) || $past(ss_wr, 2) ||
    $past(tx_take_i) || $past(tx_take_i, 2))
    else $error("tx start changed without cause");
  c_read: cover property (lb_rack_o);
  c_irq: cover property (irq_o);
  c_led: cover property ($rose(led_o));
endmodule
bind fiob_bank fiob_bank_asserts u_fiob_bank_asserts (
  .clk_i, .rst_i, .lb_addr_i, .lb_wr_i, .lb_rd_i, .lb_wdata_i,
  .lb_rdata_o, .lb_rack_o, .lb_data_oe_n_o, .tx_start_o, .tx_take_i,
  .irq_o, .led_o, .pll_sclk_o, .pll_sdata_o, .pll_sdata_oe_n_o,
  .ttl_i, .ttl_o, .ttl_oe_n_o, .ecl_o
);
`default_nettype wire

// [tb/fiob_bank_tb.sv]
// Purpose: self-checking bench for the register bank
// Assumes: blink half period of 4 cycles, fifo depths 8 and 16
// Notes: queues model both fifos and their holding words
`default_nettype none
module fiob_bank_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int DI = 8;
  localparam int DE = 16;
  logic clk_i = 0, rst_i = 1, lb_wr_i = 0, lb_rd_i = 0;
  logic tx_take_i = 0, rx_wr_i = 0, pll_low = 0;
  logic [5:0] lb_addr_i = 0;
  logic [31:0] lb_wdata_i = 0, rx_wdata_i = 0;
  logic [31:0] lb_rdata_o, tx_word_o, d, w, hw, rw, txq[$], rxq[$];
  logic [11:0] ttl_i, ttl_o, ttl_oe_n_o, ext_low = 0;
  logic [7:0] ecl_o, ecl_i = 0;
  logic lb_rack_o, lb_data_oe_n_o, tx_start_o, tx_word_valid_o;
  logic rx_start_o, irq_o, led_o, pll_sclk_o, pll_s2_o;
  logic pll_sdata_o, pll_sdata_oe_n_o, pll_sdata_i;
  logic hv = 0, rv = 0, txs = 0, lp = 0, ext = 0;
  int ae = 0, af = 0, errors = 0, check_count = 0, n;
  int seed = 32'h7EB2C08E;
  fiob_bank #(.BLINK_HALF_CYC(4), .INT_DEPTH(DI), .EXT_DEPTH(DE))
  u_fiob_bank (
    .clk_i, .rst_i, .lb_addr_i, .lb_wr_i, .lb_rd_i, .lb_wdata_i,
    .lb_rdata_o, .lb_rack_o, .lb_data_oe_n_o, .tx_start_o, .tx_word_o,
    .tx_word_valid_o, .tx_take_i, .rx_start_o, .rx_wr_i, .rx_wdata_i,
    .irq_o, .led_o, .pll_sclk_o, .pll_s2_o, .pll_sdata_o,
    .pll_sdata_oe_n_o, .pll_sdata_i, .ttl_i, .ttl_o, .ttl_oe_n_o,
    .ecl_i, .ecl_o
  );
  fiob_lines u_fiob_lines (
    .ttl_o_i(ttl_o), .ttl_oe_n_i(ttl_oe_n_o), .ext_low_i(ext_low),
    .ttl_lvl_o(ttl_i), .sd_o_i(pll_sdata_o),
    .sd_oe_n_i(pll_sdata_oe_n_o), .pll_low_i(pll_low),
    .sd_lvl_o(pll_sdata_i)
  );
  always #4 clk_i = ~clk_i;
  task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic wr(logic [5:0] a, logic [31:0] v);
    @(posedge clk_i);
    #1 {lb_wr_i, lb_addr_i, lb_wdata_i} = {1'b1, a, v};
    @(posedge clk_i);
    #1 lb_wr_i = 0;
  endtask
  task automatic rd(logic [5:0] a, output logic [31:0] v);
    @(posedge clk_i);
    #1 {lb_rd_i, lb_addr_i} = {1'b1, a};
    @(posedge clk_i);
    #1 lb_rd_i = 0;
    v = lb_rdata_o;
    chk("rack", lb_rack_o, 1);
  endtask
  task automatic rchk(logic [5:0] a, logic [31:0] e, string nm);
    rd(a, d);
    chk(nm, d, e);
  endtask
  // model moves words the way prefetch and loop-back do, then waits
  task automatic sync();
    if ((txs || lp) && !hv && txq.size() > 0) begin
      hv = 1;
      hw = txq.pop_front();
    end
    if (lp && hv) begin
      rxq.push_back(hw);
      hv = 0;
    end
    if (!rv && rxq.size() > 0) begin
      rv = 1;
      rw = rxq.pop_front();
    end
    repeat (3) @(posedge clk_i);
  endtask
  task automatic wc(logic [31:0] v);
    wr(6'h00, v);
    if (v[14]) txs = v[13];
    {ext, lp} = {v[6], v[3]};
    if (v[0]) begin
      hv = 0;
      txq.delete();
    end
    if (v[1]) begin
      rv = 0;
      rxq.delete();
    end
    sync();
  endtask
  task automatic cst();
    logic [31:0] e;
    int dt;
    dt = ext ? DE : DI;
    e = 0;
    e[3:0] = {hv, txq.size() == dt, txq.size() <= ae, txq.size() == 0};
    e[7:4] = {rv, rxq.size() == DE + DI - dt, rxq.size() >= af,
      rxq.size() == 0};
    rd(6'h04, d);
    chk("status", d & 32'hFF, e);
  endtask
  task automatic fill(int cnt);
    for (int k = 0; k < cnt; k++) begin
      w = $random(seed);
      wr(6'h0C, w);
      if (txq.size() < (ext ? DE : DI)) txq.push_back(w);
      sync();
      cst();
      rchk(6'h24, txq.size(), "txcnt");
    end
  endtask
  task automatic pulse(bit take, logic [31:0] v);
    @(posedge clk_i);
    #1 {tx_take_i, rx_wr_i, rx_wdata_i} = {take, !take, v};
    @(posedge clk_i);
    #1 {tx_take_i, rx_wr_i} = 2'b00;
  endtask
  initial begin
    repeat (50000) @(posedge clk_i);
    errors++;
    end_sim();
  end
  initial begin
    repeat (4) @(posedge clk_i);
    #1 rst_i = 0;
    rchk(6'h14, 32'hFFF, "ttl reset");
    rchk(6'h3C, 0, "unmapped");
    cst();
    wc(32'h2000);
    chk("start", tx_start_o, 0);
    wc(32'h6000);
    rchk(6'h00, 32'h2000, "ctrl");
    wc(32'h0000);
    chk("start", tx_start_o, 1);
    wc(32'h4000);
    chk("stop", tx_start_o, 0);
    $display("test start bit done");
    n = 0;
    w[0] = led_o;
    repeat (12) begin
      @(posedge clk_i);
      #1 n += (led_o !== w[0]);
      w[0] = led_o;
    end
    chk("blink", n >= 2, 1);
    wc(32'h18000);
    chk("led", led_o, 1);
    wc(32'h8000);
    chk("led", led_o, 0);
    for (int k = 0; k < 8; k++) begin
      pll_low = 1'($random(seed));
      wc({k[2], k[1], k[0], k[0], 20'h0});
      chk("sclk", pll_sclk_o, k[2] & k[0]);
      chk("s2", pll_s2_o, k[0]);
      chk("sdoe", pll_sdata_oe_n_o, !(k[2] & !k[1]));
      rd(6'h04, d);
      chk("sdin", d[15], k[2] & k[1] & !pll_low);
    end
    $display("test led and pll done");
    for (int k = 0; k < 4; k++) begin
      {ext_low, ecl_i, w} = 52'({$random(seed), $random(seed)});
      wr(6'h14, w);
      rchk(6'h14, w & 32'hFFF, "ttl out");
      rchk(6'h18, w & ~ext_low & 32'hFFF, "ttl in");
      wr(6'h1C, w);
      rchk(6'h1C, w & 32'hFF, "ecl out");
      rchk(6'h20, ecl_i, "ecl in");
    end
    ext_low = 0;
    wr(6'h14, 32'hFFF);
    $display("test ttl and ecl done");
    wr(6'h2C, 3);
    ae = 3;
    fill(DI + 1);
    wr(6'h04, 0);
    rd(6'h04, d);
    chk("ae latch", d[10], 1);
    wr(6'h04, 32'h400);
    rd(6'h04, d);
    chk("ae latch", d[10], 0);
    wc(32'h6000);
    cst();
    rchk(6'h24, DI - 1, "txcnt");
    while (hv) begin
      chk("dv", tx_word_valid_o, 1);
      chk("txword", tx_word_o, hw);
      pulse(1, 0);
      hv = 0;
      sync();
      cst();
    end
    rd(6'h04, d);
    chk("ae latch", d[10], 1);
    wc(32'h6190);
    pulse(1, 0);
    sync();
    chk("irq", irq_o, 1);
    rd(6'h04, d);
    chk("done", d[8], 1);
    chk("autoclr", tx_start_o, 0);
    txs = 0;
    wc(32'h0100);
    chk("irq", irq_o, 0);
    rd(6'h04, d);
    chk("int act", d[13], 1);
    wr(6'h04, 32'h100);
    sync();
    rd(6'h04, d);
    chk("int act", d[13:8], 6'h0C);
    wc(32'h0030);
    chk("force", irq_o, 1);
    wc(32'h0000);
    $display("test transmit done");
    wr(6'h38, 5);
    af = 5;
    wr(6'h04, 32'hF00);
    for (int k = 0; k < DE + 2; k++) begin
      w = $random(seed);
      pulse(0, w);
      if (rxq.size() < DE) rxq.push_back(w);
      sync();
    end
    cst();
    rd(6'h04, d);
    chk("overrun", d[9], 1);
    chk("af latch", d[11], 1);
    while (rv) begin
      rchk(6'h0C, rw, "rxword");
      rv = 0;
      sync();
    end
    rchk(6'h0C, 0, "rx empty");
    cst();
    wc(32'h1008);
    chk("rx start", rx_start_o, 1);
    w = $random(seed);
    wr(6'h0C, w);
    txq.push_back(w);
    sync();
    cst();
    rchk(6'h0C, rw, "loop");
    rv = 0;
    $display("test receive and loop-back done");
    wc(32'h0043);
    wc(32'h0040);
    fill(DE + 1);
    rchk(6'h24, DE, "ext count");
    $display("test fifo select done");
    end_sim();
  end
endmodule
`default_nettype wire
